//--- msto_defines.vh
`ifndef MSTO_DEFINES_VH
`define MSTO_DEFINES_VH

// Register indices; byte address is four times the index
`define MSTO_IDX_OUT1_SEL 16'h2410
`define MSTO_IDX_OUT2_SEL 16'h2411
`define MSTO_IDX_OUT3_SEL 16'h2412
`define MSTO_IDX_INP_WIN 16'h2431
`define MSTO_IDX_INP_COND 16'h2432
`define MSTO_IDX_INP_DLY 16'h2433
`define MSTO_IDX_ZSP_THR 16'h2434
`define MSTO_IDX_VM_WIN 16'h2435
`define MSTO_IDX_ARR_SPD 16'h2436
`define MSTO_IDX_IRQ_STAT 16'h2800
`define MSTO_IDX_IRQ_MASK 16'h2801
`define MSTO_IDX_FLAGS 16'h2802
`define MSTO_IDX_MASTER_OUT 16'h60fe

// Reset values
`define MSTO_RST_OUT1_SEL 8'h01
`define MSTO_RST_OUT2_SEL 8'h03
`define MSTO_RST_OUT3_SEL 8'h04
`define MSTO_RST_INP_WIN 16'h0014
`define MSTO_RST_INP_COND 16'h0001
`define MSTO_RST_INP_DLY 16'h0000
`define MSTO_RST_ZSP_THR 16'h0032
`define MSTO_RST_VM_WIN 16'h0032
`define MSTO_RST_ARR_SPD 16'h03e8

// Field positions
`define MSTO_SEL_NC_BIT 7
`define MSTO_MASTER_OUT1_BIT 16
`define MSTO_MASTER_OUT2_BIT 17
`define MSTO_MASTER_OUT3_BIT 18

// Function codes (normally-open form; bit 7 set gives normally-closed)
`define MSTO_FN_INP 5'h04
`define MSTO_FN_ZSP 5'h07

// Event bits
`define MSTO_EV_ZSP_ON 0
`define MSTO_EV_INP_ON 1
`define MSTO_EV_ZSP_OFF 2
`define MSTO_EV_INP_OFF 3

// Positioning-complete modes
`define MSTO_INP_MODE_DEV 3'd0
`define MSTO_INP_MODE_NOCMD 3'd1
`define MSTO_INP_MODE_ZSP 3'd2
`define MSTO_INP_MODE_HOLD 3'd3
`define MSTO_INP_MODE_SETTLE 3'd4

// Timing
`define MSTO_ZSP_HYST_RPM 17'd10
`define MSTO_CLK_PERIOD_NS 5
`define MSTO_MS_NS 1000000
`define MSTO_CYC_PER_MS (`MSTO_MS_NS / `MSTO_CLK_PERIOD_NS)

// Bus responses
`define MSTO_RESP_OKAY 2'b00
`define MSTO_RESP_SLVERR 2'b10

`endif

//--- msto_status_out.v
`timescale 1ns/1ps
`include "msto_defines.vh"

// Function
// R1 - Normally-open code: output goes low while selected status is true.
// R2 - Normally-closed code: output goes high while selected status is true.
// R3 - Three selection settings, one per digital output, choose the function.
// R4 - All selections zero: master object bits 16 to 18 drive outputs.
// R5 - Software writes only listed codes; unlisted codes give an inactive output.
// R6 - Zero-speed flag when absolute speed below threshold (1 to 2000, default 50); the register takes any 16-bit value.
// R7 - Ten rpm hysteresis above threshold stops zero-speed flag chattering.
// R8 - Positioning done when absolute deviation below window, per condition mode.
module msto_status_out #(
  parameter CYC_PER_MS = `MSTO_CYC_PER_MS
)(
  input wire ref_clk,
  input wire rst_n,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] drive_status,
  input wire signed [15:0] motor_speed,
  input wire signed [31:0] pos_deviation,
  input wire pos_cmd_active,
  output reg digital_output_one,
  output reg digital_output_two,
  output reg digital_output_three,
  output reg zero_speed_flag,
  output reg positioning_done_flag,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function [15:0] abs16;
    input [15:0] v;
    begin
      abs16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (~v + 32'h00000001) : v;
    end
  endfunction

  // Listed function codes only
  function code_listed;
    input [6:0] fn;
    begin
      code_listed = (fn >= 7'h01 && fn <= 7'h08) || fn == 7'h0b || fn == 7'h0d ||
                    fn == 7'h0f || fn == 7'h12 || fn == 7'h15 || fn == 7'h16;
    end
  endfunction

  // Pin level for one selection code
  function out_level;
    input [7:0] code;
    input [31:0] vec;
    reg act;
    begin
      act = code_listed(code[6:0]) && vec[code[4:0]]; // [R5]
      if (code[`MSTO_SEL_NC_BIT])
        out_level = act; // [R2]
      else
        out_level = ~act; // [R1]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] out1_sel_r;
  reg [7:0] out2_sel_r;
  reg [7:0] out3_sel_r;
  reg [15:0] inp_win_r;
  reg [15:0] inp_cond_r;
  reg [15:0] inp_dly_r;
  reg [15:0] zsp_thr_r;
  reg [15:0] vm_win_r;
  reg [15:0] arr_spd_r;
  reg [31:0] master_out_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;

  reg [17:0] aw_addr_r;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;

  wire [15:0] wr_idx = aw_addr_r[17:2];
  wire [15:0] rd_idx = s_axi_araddr[17:2];
  wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] st;
    begin
      merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  reg [31:0] ms_cnt_r;
  reg ms_tick_r;
  reg [15:0] settle_ms_r;
  reg [15:0] hold_ms_r;
  reg inp_prev_cond_r;

  wire [15:0] speed_abs = abs16(motor_speed);
  wire [31:0] dev_abs = abs32(pos_deviation);
  wire [16:0] zsp_release = {1'b0, zsp_thr_r} + `MSTO_ZSP_HYST_RPM;
  wire dev_ok = dev_abs < {16'h0000, inp_win_r}; // [R8]
  wire base_cond = dev_ok && !pos_cmd_active;
  reg zsp_nxt;
  reg inp_nxt;

  always @*
  begin
    zsp_nxt = zero_speed_flag;
    if (speed_abs < zsp_thr_r)
      zsp_nxt = 1'b1; // [R6]
    else if ({1'b0, speed_abs} >= zsp_release)
      zsp_nxt = 1'b0; // [R7]
  end

  always @*
  begin
    case (inp_cond_r[2:0])
      `MSTO_INP_MODE_DEV:
        inp_nxt = dev_ok; // [R8]
      `MSTO_INP_MODE_NOCMD:
        inp_nxt = base_cond; // [R8]
      `MSTO_INP_MODE_ZSP:
        inp_nxt = base_cond && zero_speed_flag; // [R8]
      `MSTO_INP_MODE_HOLD:
        inp_nxt = base_cond && (inp_dly_r == 16'h0000 || hold_ms_r < inp_dly_r); // [R8]
      `MSTO_INP_MODE_SETTLE:
        inp_nxt = dev_ok && !pos_cmd_active && settle_ms_r >= inp_dly_r; // [R8]
      default:
        inp_nxt = 1'b0;
    endcase
  end

  // Millisecond base and the two delay timers
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_r <= 32'h00000000;
      ms_tick_r <= 1'b0;
      settle_ms_r <= 16'h0000;
      hold_ms_r <= 16'h0000;
      inp_prev_cond_r <= 1'b0;
    end
    else
    begin
      ms_tick_r <= 1'b0;
      if (ms_cnt_r >= CYC_PER_MS - 1)
      begin
        ms_cnt_r <= 32'h00000000;
        ms_tick_r <= 1'b1;
      end
      else
        ms_cnt_r <= ms_cnt_r + 32'h00000001;
      if (pos_cmd_active)
        settle_ms_r <= 16'h0000;
      else if (ms_tick_r && settle_ms_r != 16'hffff)
        settle_ms_r <= settle_ms_r + 16'h0001;
      inp_prev_cond_r <= base_cond;
      if (base_cond && !inp_prev_cond_r)
        hold_ms_r <= 16'h0000;
      else if (ms_tick_r && hold_ms_r != 16'hffff)
        hold_ms_r <= hold_ms_r + 16'h0001;
    end
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_speed_flag <= 1'b0;
      positioning_done_flag <= 1'b0;
    end
    else
    begin
      zero_speed_flag <= zsp_nxt;
      positioning_done_flag <= inp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  reg [31:0] stat_vec;

  always @*
  begin
    stat_vec = drive_status;
    stat_vec[`MSTO_FN_INP] = positioning_done_flag;
    stat_vec[`MSTO_FN_ZSP] = zero_speed_flag;
  end

  wire master_mode = out1_sel_r == 8'h00 && out2_sel_r == 8'h00 && out3_sel_r == 8'h00;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      digital_output_one <= 1'b1;
      digital_output_two <= 1'b1;
      digital_output_three <= 1'b1;
    end
    else if (master_mode)
    begin
      digital_output_one <= master_out_r[`MSTO_MASTER_OUT1_BIT]; // [R4]
      digital_output_two <= master_out_r[`MSTO_MASTER_OUT2_BIT]; // [R4]
      digital_output_three <= master_out_r[`MSTO_MASTER_OUT3_BIT]; // [R4]
    end
    else
    begin
      digital_output_one <= out_level(out1_sel_r, stat_vec); // [R3]
      digital_output_two <= out_level(out2_sel_r, stat_vec); // [R3]
      digital_output_three <= out_level(out3_sel_r, stat_vec); // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  wire [3:0] ev;
  assign ev[`MSTO_EV_ZSP_ON] = zsp_nxt && !zero_speed_flag;
  assign ev[`MSTO_EV_INP_ON] = inp_nxt && !positioning_done_flag;
  assign ev[`MSTO_EV_ZSP_OFF] = !zsp_nxt && zero_speed_flag;
  assign ev[`MSTO_EV_INP_OFF] = !inp_nxt && positioning_done_flag;
  wire stat_rd = rd_fire && rd_idx == `MSTO_IDX_IRQ_STAT;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      // New events win over the read clear
      irq_stat_r <= (stat_rd ? 4'h0 : irq_stat_r) | ev;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSTO_RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 18'h00000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      out1_sel_r <= `MSTO_RST_OUT1_SEL;
      out2_sel_r <= `MSTO_RST_OUT2_SEL;
      out3_sel_r <= `MSTO_RST_OUT3_SEL;
      inp_win_r <= `MSTO_RST_INP_WIN;
      inp_cond_r <= `MSTO_RST_INP_COND;
      inp_dly_r <= `MSTO_RST_INP_DLY;
      zsp_thr_r <= `MSTO_RST_ZSP_THR;
      vm_win_r <= `MSTO_RST_VM_WIN;
      arr_spd_r <= `MSTO_RST_ARR_SPD;
      master_out_r <= 32'h00000000;
      irq_mask_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `MSTO_RESP_OKAY;
        if (wr_idx == `MSTO_IDX_OUT1_SEL)
          out1_sel_r <= w_strb_r[0] ? w_data_r[7:0] : out1_sel_r; // [R3]
        else if (wr_idx == `MSTO_IDX_OUT2_SEL)
          out2_sel_r <= w_strb_r[0] ? w_data_r[7:0] : out2_sel_r; // [R3]
        else if (wr_idx == `MSTO_IDX_OUT3_SEL)
          out3_sel_r <= w_strb_r[0] ? w_data_r[7:0] : out3_sel_r; // [R3]
        else if (wr_idx == `MSTO_IDX_INP_WIN)
          inp_win_r <= merge16(inp_win_r, w_data_r, w_strb_r);
        else if (wr_idx == `MSTO_IDX_INP_COND)
          inp_cond_r <= merge16(inp_cond_r, w_data_r, w_strb_r);
        else if (wr_idx == `MSTO_IDX_INP_DLY)
          inp_dly_r <= merge16(inp_dly_r, w_data_r, w_strb_r);
        else if (wr_idx == `MSTO_IDX_ZSP_THR)
          zsp_thr_r <= merge16(zsp_thr_r, w_data_r, w_strb_r); // [R6]
        else if (wr_idx == `MSTO_IDX_VM_WIN)
          vm_win_r <= merge16(vm_win_r, w_data_r, w_strb_r);
        else if (wr_idx == `MSTO_IDX_ARR_SPD)
          arr_spd_r <= merge16(arr_spd_r, w_data_r, w_strb_r);
        else if (wr_idx == `MSTO_IDX_IRQ_MASK)
          irq_mask_r <= w_strb_r[0] ? w_data_r[3:0] : irq_mask_r;
        else if (wr_idx == `MSTO_IDX_MASTER_OUT)
        begin
          master_out_r[15:0] <= merge16(master_out_r[15:0], w_data_r, w_strb_r);
          master_out_r[31:16] <= merge16(master_out_r[31:16], {16'h0000, w_data_r[31:16]},
                                         {2'b00, w_strb_r[3:2]}); // [R4]
        end
        else if (wr_idx != `MSTO_IDX_IRQ_STAT && wr_idx != `MSTO_IDX_FLAGS)
          s_axi_bresp <= `MSTO_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read

  reg [31:0] rd_data;
  reg rd_ok;

  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_idx == `MSTO_IDX_OUT1_SEL)
      rd_data = {24'h000000, out1_sel_r};
    else if (rd_idx == `MSTO_IDX_OUT2_SEL)
      rd_data = {24'h000000, out2_sel_r};
    else if (rd_idx == `MSTO_IDX_OUT3_SEL)
      rd_data = {24'h000000, out3_sel_r};
    else if (rd_idx == `MSTO_IDX_INP_WIN)
      rd_data = {16'h0000, inp_win_r};
    else if (rd_idx == `MSTO_IDX_INP_COND)
      rd_data = {16'h0000, inp_cond_r};
    else if (rd_idx == `MSTO_IDX_INP_DLY)
      rd_data = {16'h0000, inp_dly_r};
    else if (rd_idx == `MSTO_IDX_ZSP_THR)
      rd_data = {16'h0000, zsp_thr_r};
    else if (rd_idx == `MSTO_IDX_VM_WIN)
      rd_data = {16'h0000, vm_win_r};
    else if (rd_idx == `MSTO_IDX_ARR_SPD)
      rd_data = {16'h0000, arr_spd_r};
    else if (rd_idx == `MSTO_IDX_IRQ_STAT)
      rd_data = {28'h0000000, irq_stat_r};
    else if (rd_idx == `MSTO_IDX_IRQ_MASK)
      rd_data = {28'h0000000, irq_mask_r};
    else if (rd_idx == `MSTO_IDX_FLAGS)
      rd_data = {27'h0000000, digital_output_three, digital_output_two, digital_output_one,
                 positioning_done_flag, zero_speed_flag};
    else if (rd_idx == `MSTO_IDX_MASTER_OUT)
      rd_data = master_out_r;
    else
      rd_ok = 1'b0;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MSTO_RESP_OKAY;
    end
    else
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `MSTO_RESP_OKAY : `MSTO_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- msto_equip_model.sv
`timescale 1ns/1ps
module msto_equip #(
  parameter signed [15:0] STEP = 16'sh0004
)(
  input wire ref_clk,
  input wire rst_n,
  input wire signed [15:0] speed_target,
  output reg signed [15:0] motor_speed
);
  // Motor inertia: speed moves toward target a few rpm per cycle
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      motor_speed <= 16'sh0000;
    else if (motor_speed < speed_target - STEP)
      motor_speed <= motor_speed + STEP;
    else if (motor_speed > speed_target + STEP)
      motor_speed <= motor_speed - STEP;
    else
      motor_speed <= speed_target;
endmodule

//--- msto_status_out_asserts.sv
`timescale 1ns/1ps
`include "msto_defines.vh"
module msto_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [31:0] drive_status,
  input wire signed [15:0] motor_speed,
  input wire signed [31:0] pos_deviation,
  input wire pos_cmd_active,
  input wire digital_output_one,
  input wire digital_output_two,
  input wire digital_output_three,
  input wire zero_speed_flag,
  input wire positioning_done_flag,
  input wire irq
);
  reg [7:0] sel [0:2];
  reg [15:0] thr;
  reg [15:0] mode;
  reg [2:0] mo;
  reg [2:0] age;
  wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire signed [16:0] spd = motor_speed;
  wire [16:0] sa = spd[16] ? -spd : spd;
  wire [16:0] hi = {1'b0, thr} + `MSTO_ZSP_HYST_RPM;
  wire signed [32:0] dv = pos_deviation;
  wire [32:0] da = dv[32] ? -dv : dv;
  wire all0 = sel[0] == 8'h00 && sel[1] == 8'h00 && sel[2] == 8'h00;
  wire [2:0] dout = {digital_output_three, digital_output_two, digital_output_one};
  ////////////////////////////////////////////////////////////////
  // Shadow of the settings; age counts quiet cycles since a write
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sel[0] <= `MSTO_RST_OUT1_SEL;
      sel[1] <= `MSTO_RST_OUT2_SEL;
      sel[2] <= `MSTO_RST_OUT3_SEL;
      thr <= `MSTO_RST_ZSP_THR;
      mode <= `MSTO_RST_INP_COND;
      mo <= 3'h0;
      age <= 3'h0;
    end
    else if (wr)
    begin
      age <= 3'h0;
      case (s_axi_awaddr[17:2])
        `MSTO_IDX_OUT1_SEL: sel[0] <= s_axi_wdata[7:0];
        `MSTO_IDX_OUT2_SEL: sel[1] <= s_axi_wdata[7:0];
        `MSTO_IDX_OUT3_SEL: sel[2] <= s_axi_wdata[7:0];
        `MSTO_IDX_ZSP_THR: thr <= s_axi_wdata[15:0];
        `MSTO_IDX_INP_COND: mode <= s_axi_wdata[15:0];
        `MSTO_IDX_MASTER_OUT: mo <= s_axi_wdata[18:16];
        default: ;
      endcase
    end
    else if (age != 3'h7)
      age <= age + 3'h1;
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_open_low: assert property (age == 3'h7 && sel[0] == 8'h03 && $stable(drive_status[3])
    |=> digital_output_one == !$past(drive_status[3])) else $error("out1 open level wrong");
  chk_closed_high: assert property (age == 3'h7 && sel[0] == 8'h83 && $stable(drive_status[3])
    |=> digital_output_one == $past(drive_status[3])) else $error("out1 closed level wrong");
  chk_third_sel: assert property (age == 3'h7 && sel[2] == 8'h02 && $stable(drive_status[2])
    |=> digital_output_three == !$past(drive_status[2])) else $error("out3 select wrong");
  chk_master_out: assert property (age == 3'h7 && all0 && $stable(mo)
    |=> dout == $past(mo)) else $error("master bits not on outputs");
  chk_zsp_set: assert property (age == 3'h7 && $stable(motor_speed) && sa < {1'b0, thr}
    |=> zero_speed_flag) else $error("zero speed not flagged");
  chk_zsp_clear: assert property (age == 3'h7 && $stable(motor_speed) && sa >= hi
    |=> !zero_speed_flag) else $error("zero speed not cleared");
  chk_zsp_hold: assert property (zero_speed_flag && age == 3'h7 && $stable(motor_speed) && sa < hi
    |=> zero_speed_flag) else $error("zero speed dropped in band");
  chk_inp_done: assert property (age == 3'h7 && mode == 16'h0001 && $stable(pos_deviation)
    && $stable(pos_cmd_active) |=> positioning_done_flag == (!$past(pos_cmd_active)
    && $past(da) < {17'h0, `MSTO_RST_INP_WIN})) else $error("positioning flag wrong");
  cov_open_low: cover property (sel[0] == 8'h03 && !digital_output_one);
  cov_zsp_rise: cover property ($rose(zero_speed_flag));
  cov_irq: cover property ($rose(irq));
  cov_master: cover property (all0 && dout == 3'h5);
endmodule
bind msto_status_out msto_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .drive_status(drive_status),
  .motor_speed(motor_speed), .pos_deviation(pos_deviation), .pos_cmd_active(pos_cmd_active),
  .digital_output_one(digital_output_one), .digital_output_two(digital_output_two),
  .digital_output_three(digital_output_three), .zero_speed_flag(zero_speed_flag),
  .positioning_done_flag(positioning_done_flag), .irq(irq));

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  reg ref_clk, rst_n, pos_cmd_active;
  reg [17:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, drive_status, rdv;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg signed [31:0] pos_deviation;
  reg signed [15:0] speed_t;
  reg [1:0] rsp;
  wire signed [15:0] motor_speed;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] dout;
  wire zero_speed_flag, positioning_done_flag, irq;
  integer errors, checked, cyc, i, o;
  logic [15:0] ri [0:8] = '{16'h2410, 16'h2411, 16'h2412, 16'h2431, 16'h2432, 16'h2433, 16'h2434, 16'h2435, 16'h2436};
  logic [15:0] rv [0:8] = '{16'h01, 16'h03, 16'h04, 16'h14, 16'h1, 16'h0, 16'h32, 16'h32, 16'h3e8};
  logic [7:0] fc [0:11] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h0b, 8'h0d, 8'h0f, 8'h12, 8'h15, 8'h16};
  logic [15:0] zs [0:9] = '{16'h64, 16'h31, 16'h37, 16'h3b, 16'h3c, 16'h32, 16'hffcf, 16'hffc5, 16'hffc4, 16'h0};
  logic [9:0] ze = 10'h2ce;
  logic [31:0] pd [0:3] = '{32'h13, 32'h14, 32'hffffffed, 32'h0};
  msto_status_out #(.CYC_PER_MS(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .drive_status(drive_status), .motor_speed(motor_speed),
    .pos_deviation(pos_deviation), .pos_cmd_active(pos_cmd_active), .digital_output_one(dout[0]),
    .digital_output_two(dout[1]), .digital_output_three(dout[2]), .zero_speed_flag(zero_speed_flag),
    .positioning_done_flag(positioning_done_flag), .irq(irq));
  msto_equip #(.STEP(16'sh0004)) u_eq (.ref_clk(ref_clk), .rst_n(rst_n), .speed_target(speed_t),
    .motor_speed(motor_speed));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task wr(input [15:0] idx, input [31:0] d);
    reg done;
  begin
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        done = 1'b1;
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  end
  endtask
  task wrk(input [15:0] idx, input [31:0] d);
  begin
    wr(idx, d);
    chk("bresp", rsp, 2'b00);
  end
  endtask
  task rd(input [15:0] idx);
    reg done;
  begin
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        done = 1'b1;
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  end
  endtask
  task st(input [31:0] v);
  begin
    @(posedge ref_clk);
    drive_status <= v;
    repeat (8) @(posedge ref_clk);
  end
  endtask
  task pos(input c, input [31:0] v);
  begin
    @(posedge ref_clk);
    pos_cmd_active <= c;
    pos_deviation <= v;
    repeat (8) @(posedge ref_clk);
  end
  endtask
  task spin(input [15:0] s);
  begin
    @(posedge ref_clk);
    speed_t <= s;
    while (motor_speed !== s)
      @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      complete_run;
    end
  end
  initial
  begin
    errors = 0;
    checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 18'h0;
    s_axi_araddr = 18'h0;
    s_axi_wdata = 32'h0;
    drive_status = 32'h0;
    pos_deviation = 32'sh0;
    pos_cmd_active = 1'b1;
    speed_t = 16'sh0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
    begin
      rd(ri[i]);
      chk("default", rdv, {16'h0, rv[i]});
    end
    rd(16'h2900);
    chk("rresp", rsp, 2'b10);
    wr(16'h2900, 32'h5);
    chk("bresp", rsp, 2'b10);
    // Twelve function codes, each on one output in turn, open then closed form
    for (i = 0; i < 12; i = i + 1)
    begin
      o = (i + 1) % 3;
      wrk(16'h2410 + o, {24'h0, fc[i]});
      st(32'h1 << fc[i][4:0]);
      chk("open_on", dout[o], 1'b0);
      st(32'h0);
      chk("open_off", dout[o], 1'b1);
      wrk(16'h2410 + o, {24'h0, fc[i] | 8'h80});
      st(32'h0);
      chk("closed_off", dout[o], 1'b0);
      st(32'h1 << fc[i][4:0]);
      chk("closed_on", dout[o], 1'b1);
    end
    wrk(16'h60fe, 32'h0005_0000);
    for (i = 0; i < 3; i = i + 1)
      wrk(16'h2410 + i, 32'h0);
    st(32'h0);
    chk("master", dout, 3'h5);
    wrk(16'h60fe, 32'h0002_0000);
    st(32'h0);
    chk("master", dout, 3'h2);
    wrk(16'h2410, 32'h07);
    for (i = 0; i < 10; i = i + 1)
    begin
      spin(zs[i]);
      chk("zsp", zero_speed_flag, ze[i]);
      chk("zsp_pin", dout[0], !ze[i]);
    end
    wrk(16'h2434, 32'd2000);
    spin(16'h07cf);
    chk("zsp_max", zero_speed_flag, 1'b1);
    spin(16'h07da);
    chk("zsp_max", zero_speed_flag, 1'b0);
    spin(16'h07d9);
    chk("zsp_max", zero_speed_flag, 1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      pos(i == 3, pd[i]);
      chk("inp", positioning_done_flag, i == 0 || i == 2);
    end
    wrk(16'h2432, 32'h0);
    pos(1'b1, 32'h5);
    chk("inp_mode0", positioning_done_flag, 1'b1);
    // Mode 2 needs the zero-speed flag as well
    wrk(16'h2432, 32'h2);
    pos(1'b0, 32'h5);
    chk("inp_mode2", positioning_done_flag, 1'b0);
    wrk(16'h2434, 32'h7da);
    st(32'h0);
    chk("inp_mode2", positioning_done_flag, 1'b1);
    rd(16'h2802);
    chk("flags", rdv, 32'h1b);
    // Mode 3 holds for the delay, mode 4 waits for it
    wrk(16'h2432, 32'h3);
    wrk(16'h2433, 32'h3);
    pos(1'b1, 32'h5);
    pos(1'b0, 32'h5);
    chk("inp_mode3", positioning_done_flag, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk("inp_mode3", positioning_done_flag, 1'b0);
    wrk(16'h2432, 32'h4);
    pos(1'b1, 32'h5);
    pos(1'b0, 32'h5);
    chk("inp_mode4", positioning_done_flag, 1'b0);
    repeat (40) @(posedge ref_clk);
    chk("inp_mode4", positioning_done_flag, 1'b1);
    wrk(16'h2432, 32'h5);
    st(32'h0);
    chk("inp_mode5", positioning_done_flag, 1'b0);
    wrk(16'h2434, 32'h32);
    wrk(16'h2801, 32'h1);
    spin(16'h64);
    rd(16'h2800);
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 1'b0);
    spin(16'h0);
    chk("irq", irq, 1'b1);
    rd(16'h2800);
    chk("stat", rdv[0], 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 1'b0);
    wrk(16'h2801, 32'h0);
    spin(16'h64);
    chk("irq", irq, 1'b0);
    rd(16'h2800);
    chk("stat", rdv[2], 1'b1);
    complete_run;
  end
endmodule
